// ==== shared/dsb_regs.svh ====
// constants for the burst-of-two separate-io sram port
`ifndef DSB_REGS_SVH
`define DSB_REGS_SVH

// width of one byte lane of write data
`define DSB_LANE_W 9
// link clock edges in one input clock cycle (K rise and K# rise)
`define DSB_EDGES_PER_CYC 2
// input clock cycles before the delay loop counts as locked again
`define DSB_RESTART_CYC 1024
// non-read cycles before the output impedance is settled
`define DSB_ZQ_CYC 1024
// depth of the read and write edge pipelines
`define DSB_RD_DEPTH 4
`define DSB_WR_DEPTH 3
// pipeline taps: the edge before a word moves
`define DSB_RD_W0_TAP 2
`define DSB_RD_W1_TAP 3
`define DSB_WR_W0_TAP 1
`define DSB_WR_W1_TAP 2
// burst counter start and step
`define DSB_BURST_FIRST 1'h0
`define DSB_BURST_NEXT 1'h1
// link edges after reset release before the mode strap is taken
`define DSB_STRAP_WAIT 2'h2

`endif

// ==== shared/dsb_pkg.sv ====
// types shared by the burst-of-two sram port
package dsb_pkg;

    // state of the current input clock cycle at the link
    typedef enum logic [2:0] {
        DSB_ST_DESEL = 3'b001,
        DSB_ST_READ  = 3'b010,
        DSB_ST_WRITE = 3'b100
    } dsb_cyc_t;

endpackage

// ==== core/dsb_sram_port.sv ====
// burst-of-two ddr separate-io sram port with loop and impedance control
`timescale 1ns/1ps
`include "dsb_regs.svh"

module dsb_sram_port #(
    parameter int SA_W       = 19,
    parameter int DATA_W     = 36,
    parameter int IMP_W      = 6,
    parameter int ABSENT_CYC = 8
) (
    // system clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // link clock, one rise per K rise and per K# rise
    input  wire logic                 k_edge_clk,
    input  wire logic                 k_level,
    // command inputs
    input  wire logic                 cycle_load_n,
    input  wire logic                 rw_sel,
    input  wire logic [SA_W-1:0]      shared_address,
    // write data and byte enables
    input  wire logic [DATA_W-1:0]    d,
    input  wire logic                 byte_enable0_n,
    input  wire logic                 byte_enable1_n,
    input  wire logic                 byte_enable2_n,
    input  wire logic                 byte_enable3_n,
    // static pins
    input  wire logic                 dll_off_n,
    input  wire logic                 out_clk_held_high,
    input  wire logic [IMP_W-1:0]     impedance_ref,
    // read data and echo clocks
    output wire logic [DATA_W-1:0]    q,
    output wire logic                 q_oe,
    output wire logic [1:0]           echo_strobe_pair,
    // status
    output wire dsb_pkg::dsb_cyc_t    link_state,
    output wire logic                 out_clk_from_k,
    output wire logic                 dll_enable,
    output wire logic                 dll_ready,
    output wire logic [IMP_W-1:0]     imp_code,
    output wire logic                 imp_ready,
    output wire logic                 k_clock_absent
);
    import dsb_pkg::*;

    // ****************************************************************
    // derived sizes
    // ****************************************************************
    localparam int LANES  = DATA_W / `DSB_LANE_W;
    localparam int AW     = SA_W + 1;
    localparam int DEPTH  = 2 ** AW;
    localparam int CNT_W  = 12;
    localparam int ZQ_W   = 11;
    localparam int IDLE_W = 8;
    localparam int LOCK_EDGES = `DSB_RESTART_CYC * `DSB_EDGES_PER_CYC;
    localparam logic [CNT_W-1:0]  LOCK_LAST = CNT_W'(LOCK_EDGES - 1);
    localparam logic [ZQ_W-1:0]   ZQ_LAST   = ZQ_W'(`DSB_ZQ_CYC - 1);
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(ABSENT_CYC - 1);

    // ****************************************************************
    // link reset, released on the link clock
    // ****************************************************************
    logic k_rst_s1_ff;
    logic k_rst_ff;

    // reset asserts at once and leaves after two link edges
    always_ff @(posedge k_edge_clk or posedge reset) begin
        if (reset) begin
            k_rst_s1_ff <= 1'b1;
            k_rst_ff    <= 1'b1;
        end else begin
            k_rst_s1_ff <= 1'b0;
            k_rst_ff    <= k_rst_s1_ff;
        end
    end

    // ****************************************************************
    // static pins brought onto the link clock
    // ****************************************************************
    logic [IMP_W+1:0] stat_s1_ff;
    logic [IMP_W+1:0] stat_s2_ff;
    logic             lost_s1_ff;
    logic             lost_s2_ff;
    logic             k_absent_ff;
    wire  [IMP_W+1:0] stat_pins = {dll_off_n, out_clk_held_high, impedance_ref};
    wire              dll_on    = stat_s2_ff[IMP_W+1];
    wire              held_high = stat_s2_ff[IMP_W];
    wire  [IMP_W-1:0] imp_req   = stat_s2_ff[IMP_W-1:0];

    // two-stage synchronisers for the pins and the absence flag
    always_ff @(posedge k_edge_clk or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            stat_s1_ff <= '0;
            stat_s2_ff <= '0;
            lost_s1_ff <= 1'b0;
            lost_s2_ff <= 1'b0;
        end else begin
            stat_s1_ff <= stat_pins;
            stat_s2_ff <= stat_s1_ff;
            lost_s1_ff <= k_absent_ff;
            lost_s2_ff <= lost_s1_ff;
        end
    end

    // ****************************************************************
    // command decode
    // ****************************************************************
    // only K rises start a cycle; K# rises carry data only
    wire cyc_load = k_level & ~cycle_load_n;
    wire rd_new   = cyc_load & rw_sel;
    wire wr_new   = cyc_load & ~rw_sel;
    wire [3:0] be_all_n = {byte_enable3_n, byte_enable2_n,
                           byte_enable1_n, byte_enable0_n};

    dsb_cyc_t cyc_ff;
    dsb_cyc_t nxt_cyc;

    // next cycle state, held across K# rises
    always_comb begin
        nxt_cyc = cyc_ff;
        case (cyc_ff)
            DSB_ST_DESEL,
            DSB_ST_READ,
            DSB_ST_WRITE: begin
                if (k_level) begin
                    if (rd_new) begin
                        nxt_cyc = DSB_ST_READ;
                    end else if (wr_new) begin
                        nxt_cyc = DSB_ST_WRITE;
                    end else begin
                        nxt_cyc = DSB_ST_DESEL;
                    end
                end
            end
            default: nxt_cyc = DSB_ST_DESEL;
        endcase
    end

    // cycle state register
    always_ff @(posedge k_edge_clk or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            cyc_ff <= DSB_ST_DESEL;
        end else begin
            cyc_ff <= nxt_cyc;
        end
    end

    // ****************************************************************
    // read and write edge pipelines
    // ****************************************************************
    // state holds while the link clock stands, so a burst caught before
    // a clock stop completes on the first edges after the restart
    logic [`DSB_RD_DEPTH-1:0] rd_vld_ff;
    logic [SA_W-1:0]          rd_addr_ff [`DSB_RD_DEPTH];
    logic [`DSB_WR_DEPTH-1:0] wr_vld_ff;
    logic [SA_W-1:0]          wr_addr_ff [`DSB_WR_DEPTH];

    // shift one stage per link edge
    always_ff @(posedge k_edge_clk or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            rd_vld_ff <= '0;
            wr_vld_ff <= '0;
        end else begin
            rd_vld_ff <= {rd_vld_ff[`DSB_RD_DEPTH-2:0], rd_new};
            wr_vld_ff <= {wr_vld_ff[`DSB_WR_DEPTH-2:0], wr_new};
        end
    end

    // addresses travel beside their valid bits
    always_ff @(posedge k_edge_clk) begin
        rd_addr_ff[0] <= shared_address;
        wr_addr_ff[0] <= shared_address;
        for (int i = 1; i < `DSB_RD_DEPTH; i++) begin
            rd_addr_ff[i] <= rd_addr_ff[i-1];
        end
        for (int i = 1; i < `DSB_WR_DEPTH; i++) begin
            wr_addr_ff[i] <= wr_addr_ff[i-1];
        end
    end

    // ****************************************************************
    // memory array and byte-gated writes
    // ****************************************************************
    logic [DATA_W-1:0] mem [DEPTH];

    // write beats: first on the next K rise, second on the K# after it
    wire wr_beat0 = wr_vld_ff[`DSB_WR_W0_TAP];
    wire wr_beat1 = wr_vld_ff[`DSB_WR_W1_TAP];
    wire wr_go    = wr_beat0 | wr_beat1;
    wire [AW-1:0] wr_word = wr_beat0 ?
        {wr_addr_ff[`DSB_WR_W0_TAP], `DSB_BURST_FIRST} :
        {wr_addr_ff[`DSB_WR_W1_TAP], `DSB_BURST_NEXT};
    wire [DATA_W-1:0] wr_mask;

    // lane enables are taken fresh on every beat
    genvar g;
    generate
        for (g = 0; g < DATA_W; g++) begin : g_mask
            assign wr_mask[g] = ~be_all_n[g / `DSB_LANE_W];
        end
    endgenerate

    // masked store of one word per beat
    always_ff @(posedge k_edge_clk) begin
        if (wr_go) begin
            mem[wr_word] <= (mem[wr_word] & ~wr_mask) | (d & wr_mask);
        end
    end

    // ****************************************************************
    // read data launch and echo clocks
    // ****************************************************************
    logic [DATA_W-1:0] q_ff;
    logic              q_oe_ff;
    logic [1:0]        echo_ff;
    wire rd_beat0 = rd_vld_ff[`DSB_RD_W0_TAP];
    wire rd_beat1 = rd_vld_ff[`DSB_RD_W1_TAP];
    wire [AW-1:0] rd_word = rd_beat0 ?
        {rd_addr_ff[`DSB_RD_W0_TAP], `DSB_BURST_FIRST} :
        {rd_addr_ff[`DSB_RD_W1_TAP], `DSB_BURST_NEXT};

    // drivers follow pending beats; with none they fall to high-z
    always_ff @(posedge k_edge_clk or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            q_oe_ff <= 1'b0;
            echo_ff <= 2'h1;
        end else begin
            q_oe_ff <= rd_beat0 | rd_beat1;
            echo_ff <= {~k_level, k_level};
        end
    end

    // data launched on the same edges as the echo pair
    always_ff @(posedge k_edge_clk) begin
        if (rd_beat0 | rd_beat1) begin
            q_ff <= mem[rd_word];
        end
    end

    // ****************************************************************
    // output clock mode strap
    // ****************************************************************
    logic [1:0] st_cnt_ff;
    logic       strap_done_ff;
    logic       from_k_ff;

    // taken once after the synchronisers fill, never again
    always_ff @(posedge k_edge_clk or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            st_cnt_ff     <= 2'h0;
            strap_done_ff <= 1'b0;
            from_k_ff     <= 1'b0;
        end else if (!strap_done_ff) begin
            st_cnt_ff <= st_cnt_ff + 2'h1;
            if (st_cnt_ff == `DSB_STRAP_WAIT) begin
                strap_done_ff <= 1'b1;
                from_k_ff     <= held_high;
            end
        end
    end

    // ****************************************************************
    // delay loop enable and restart count
    // ****************************************************************
    logic             dll_en_ff;
    logic             dll_rdy_ff;
    logic [CNT_W-1:0] lock_cnt_ff;
    wire              lock_hold = ~dll_on | lost_s2_ff;

    // count a full restart after the loop is enabled or the clock returns
    always_ff @(posedge k_edge_clk or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            dll_en_ff   <= 1'b0;
            dll_rdy_ff  <= 1'b0;
            lock_cnt_ff <= '0;
        end else begin
            dll_en_ff <= dll_on;
            if (lock_hold) begin
                lock_cnt_ff <= '0;
                dll_rdy_ff  <= 1'b0;
            end else begin
                if (lock_cnt_ff != LOCK_LAST) begin
                    lock_cnt_ff <= lock_cnt_ff + 1'b1;
                end
                dll_rdy_ff <= (lock_cnt_ff == LOCK_LAST);
            end
        end
    end

    // ****************************************************************
    // output impedance updates
    // ****************************************************************
    logic [IMP_W-1:0] imp_ff;
    logic [ZQ_W-1:0]  zq_cnt_ff;
    logic             zq_rdy_ff;
    wire              quiet_cyc = k_level & ~(|rd_vld_ff) & ~rd_new;

    // new codes go in only at the start of a cycle that drives nothing
    always_ff @(posedge k_edge_clk or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            imp_ff    <= '0;
            zq_cnt_ff <= '0;
            zq_rdy_ff <= 1'b0;
        end else begin
            if (quiet_cyc) begin
                imp_ff <= imp_req;
            end
            if (k_level && !rd_new && zq_cnt_ff != ZQ_LAST) begin
                zq_cnt_ff <= zq_cnt_ff + 1'b1;
            end
            zq_rdy_ff <= (zq_cnt_ff == ZQ_LAST);
        end
    end

    // ****************************************************************
    // input clock absence detection on the system clock
    // ****************************************************************
    logic              alive_ff;
    logic              alive_s1_ff;
    logic              alive_s2_ff;
    logic              alive_s3_ff;
    logic [IDLE_W-1:0] idle_cnt_ff;

    // heartbeat toggled on every link edge
    always_ff @(posedge k_edge_clk or posedge k_rst_ff) begin
        if (k_rst_ff) begin
            alive_ff <= 1'b0;
        end else begin
            alive_ff <= ~alive_ff;
        end
    end

    // heartbeat crossing and silence counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alive_s1_ff <= 1'b0;
            alive_s2_ff <= 1'b0;
            alive_s3_ff <= 1'b0;
            idle_cnt_ff <= '0;
            k_absent_ff <= 1'b0;
        end else begin
            alive_s1_ff <= alive_ff;
            alive_s2_ff <= alive_s1_ff;
            alive_s3_ff <= alive_s2_ff;
            if (alive_s2_ff != alive_s3_ff) begin
                idle_cnt_ff <= '0;
                k_absent_ff <= 1'b0;
            end else if (idle_cnt_ff != IDLE_LAST) begin
                idle_cnt_ff <= idle_cnt_ff + 1'b1;
            end else begin
                k_absent_ff <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign q                = q_ff;
    assign q_oe             = q_oe_ff;
    assign echo_strobe_pair = echo_ff;
    assign link_state       = cyc_ff;
    assign out_clk_from_k   = from_k_ff;
    assign dll_enable       = dll_en_ff;
    assign dll_ready        = dll_rdy_ff;
    assign imp_code         = imp_ff;
    assign imp_ready        = zq_rdy_ff;
    assign k_clock_absent   = k_absent_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence seq_rd_cmd;
        rd_new;
    endsequence

    sequence seq_rd_burst;
        q_oe_ff ##1 q_oe_ff;
    endsequence

    sequence seq_wr_beats;
        wr_beat0 ##1 wr_beat1;
    endsequence

    chk_read_burst:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        seq_rd_cmd |-> ##4 seq_rd_burst)
        else $error("read burst not launched on time");

    chk_read_stream:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        rd_new ##2 rd_new |-> ##2 q_oe_ff [*4])
        else $error("gap between back-to-back read bursts");

    chk_desel_hiz:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        (!rd_new) [*5] |=> !q_oe_ff)
        else $error("outputs driven with no read pending");

    chk_write_beats:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        wr_new |-> ##2 seq_wr_beats)
        else $error("write beats not taken on time");

    chk_nop_idle:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        (k_level && cycle_load_n) |-> !rd_new && !wr_new)
        else $error("command taken with load high");

    chk_echo_toggle:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        (k_level != $past(k_level)) |=>
        (echo_ff[0] == $past(k_level)) && (echo_ff[0] != echo_ff[1]))
        else $error("echo pair stopped toggling");

    chk_dll_off:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        !dll_on |=> !dll_en_ff && !dll_rdy_ff)
        else $error("delay loop active while disabled");

    chk_restart_wait:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        $rose(dll_rdy_ff) |-> lock_cnt_ff == LOCK_LAST)
        else $error("delay loop ready before restart count");

    chk_absent_reset:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        lost_s2_ff |=> !dll_rdy_ff && lock_cnt_ff == '0)
        else $error("delay loop not reset on absent clock");

    chk_imp_quiet:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        $changed(imp_ff) |-> !q_oe_ff && !$past(q_oe_ff))
        else $error("impedance changed while driving");

    chk_mode_fixed:
    assert property (@(posedge k_edge_clk) disable iff (k_rst_ff)
        strap_done_ff |=> $stable(from_k_ff))
        else $error("output clock mode changed after start");

endmodule

// ==== tb/dsb_ctrl_model.sv ====
// controller-side model: link clock, commands and write data
`timescale 1ns/1ps
module dsb_ctrl_model #(
    parameter int SA_W   = 19,
    parameter int DATA_W = 36
) (
    // link clock and its phase
    output logic              k_edge_clk,
    output logic              k_level,
    // command, write data and byte enables
    output logic              cycle_load_n,
    output logic              rw_sel,
    output logic [SA_W-1:0]   shared_address,
    output logic [DATA_W-1:0] d,
    output logic [3:0]        be_n
);
    logic run = 1'b1;
    int   ecnt = 0;
    event fell;

    // one rise per K and K# rise; the clock stalls while run is low
    initial begin
        k_edge_clk = 1'b0;
        k_level = 1'b0;
        cycle_load_n = 1'b1;
        rw_sel = 1'b1;
        shared_address = '0;
        d = '0;
        be_n = 4'hf;
        #3;
        forever begin
            if (run) begin
                #6 k_edge_clk = 1'b1;
                ecnt++;
                #6 k_edge_clk = 1'b0;
                k_level = ~k_level;
                -> fell;
            end else begin
                #6;
            end
        end
    end

    // one K cycle: command and first beat at K rise, second beat at K# rise
    task automatic kcyc(input logic ld_n, input logic rw, input logic [SA_W-1:0] a,
                        input logic [DATA_W-1:0] d0, input logic [3:0] m0,
                        input logic [DATA_W-1:0] d1, input logic [3:0] m1);
        do @fell; while (!k_level);
        cycle_load_n = ld_n; // load low opens a cycle
        rw_sel = rw; // high reads, low writes
        shared_address = a; // address for the K rise
        d = d0; // beat on K rise
        be_n = m0; // active-low lanes
        @fell;
        cycle_load_n = 1'b1;
        rw_sel = ~rw;
        shared_address = ~a;
        d = d1; // beat on K# rise
        be_n = m1;
    endtask
endmodule

// ==== tb/dsb_sram_port_tb.sv ====
// self-checking bench for the burst-of-two sram port
`timescale 1ns/1ps
module dsb_sram_port_tb;
    import dsb_pkg::*;
    localparam logic [35:0] G = 36'hbadbadbad;
    logic        clk, reset, dll_off_n, out_clk_held_high, mon_on, prev_echo, wv;
    logic [5:0]  impedance_ref;
    logic [18:0] wa;
    logic [35:0] mem [int] = '{default: 36'h0};
    logic [35:0] exp_q [int];
    int          error_cnt = 0;
    int          total_checks = 0;
    wire         k_edge_clk, k_level, cycle_load_n, rw_sel, q_oe, out_clk_from_k;
    wire         dll_enable, dll_ready, imp_ready, k_clock_absent;
    wire [18:0]  shared_address;
    wire [35:0]  d, q;
    wire [3:0]   be_n;
    wire [1:0]   echo_strobe_pair;
    wire [5:0]   imp_code;
    wire dsb_cyc_t link_state;

    // controller model and the port under test
    dsb_ctrl_model ctrl (.k_edge_clk(k_edge_clk), .k_level(k_level),
        .cycle_load_n(cycle_load_n), .rw_sel(rw_sel), .shared_address(shared_address),
        .d(d), .be_n(be_n));
    dsb_sram_port DUT (.clk(clk), .reset(reset), .k_edge_clk(k_edge_clk), .k_level(k_level),
        .cycle_load_n(cycle_load_n), .rw_sel(rw_sel), .shared_address(shared_address), .d(d),
        .byte_enable0_n(be_n[0]), .byte_enable1_n(be_n[1]), .byte_enable2_n(be_n[2]),
        .byte_enable3_n(be_n[3]), .dll_off_n(dll_off_n), .out_clk_held_high(out_clk_held_high),
        .impedance_ref(impedance_ref), .q(q), .q_oe(q_oe), .echo_strobe_pair(echo_strobe_pair),
        .link_state(link_state), .out_clk_from_k(out_clk_from_k), .dll_enable(dll_enable),
        .dll_ready(dll_ready), .imp_code(imp_code), .imp_ready(imp_ready),
        .k_clock_absent(k_clock_absent));

    // system clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] want, input string what);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("FAIL %0t %s: got %h want %h", $time, what, seen, want);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                          input logic [3:0] m);
        for (int i = 0; i < 4; i++)
            if (!m[i]) old[9*i +: 9] = nw[9*i +: 9]; // low enable stores lane i
        return old;
    endfunction

    // read port and echo pair watched on every link edge
    always @(ctrl.fell) begin
        if (mon_on) begin
            check(q_oe, exp_q.exists(ctrl.ecnt), "drive"); // no gaps, then off
            if (exp_q.exists(ctrl.ecnt))
                check(q, exp_q[ctrl.ecnt], "word"); // word timing
            check(echo_strobe_pair, {prev_echo, ~prev_echo}, "echo"); // toggling
        end
        prev_echo = echo_strobe_pair[0];
    end

    // one K cycle with bookkeeping of stored and expected words
    task automatic cyc(input logic ld, input logic rw, input logic [18:0] a,
                       input logic [35:0] d0, input logic [35:0] d1,
                       input logic [3:0] m0, input logic [3:0] m1);
        int c;
        ctrl.kcyc(ld, rw, a, d0, m0, d1, m1);
        c = ctrl.ecnt;
        check(link_state, ld ? DSB_ST_DESEL : (rw ? DSB_ST_READ : DSB_ST_WRITE), "kind");
        if (wv) begin
            mem[{wa, 1'b0}] = merge(mem[{wa, 1'b0}], d0, m0); // beat masks
            mem[{wa, 1'b1}] = merge(mem[{wa, 1'b1}], d1, m1); // beat masks
        end
        wv = !ld && !rw;
        wa = a;
        if (!ld && rw) begin
            exp_q[c + 3] = mem[{a, 1'b0}]; // base word
            exp_q[c + 4] = mem[{a, 1'b1}]; // base plus one
        end
    endtask

    task automatic wr(input logic [18:0] a, input logic [35:0] d0, input logic [35:0] d1,
                      input logic [3:0] m0, input logic [3:0] m1);
        cyc(1'b0, 1'b0, a, G, ~G, 4'h0, 4'h0);
        cyc(1'b1, 1'b0, 19'h0, d0, d1, m0, m1);
    endtask

    // quiet cycles with junk data on every lane
    task automatic idle(input int n);
        repeat (n) cyc(1'b1, 1'b0, 19'h0, G, ~G, 4'h0, 4'h0); // junk ignored
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_power();
        repeat (1000) @(ctrl.fell);
        check({dll_ready, imp_ready}, 2'b00, "early"); // still settling
        repeat (1300) @(ctrl.fell);
        check({dll_enable, dll_ready, imp_ready, out_clk_from_k}, 4'b1110, "up");
        check(imp_code, 6'h2a, "imp code"); // applied while quiet
        $display("power-up test done");
    endtask

    task automatic t_stream();
        cyc(1'b0, 1'b0, 19'h10, G, ~G, 4'h0, 4'h0);
        cyc(1'b0, 1'b0, 19'h11, 36'h111111111, 36'h222222222, 4'h0, 4'h0); // back to back
        cyc(1'b1, 1'b0, 19'h0, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
        idle(2);
        for (int k = 0; k < 8; k++) begin
            cyc(1'b0, 1'b1, 19'h10 + 19'(k % 2), G, ~G, 4'h0, 4'h0); // streamed reads
            if (k == 0)
                impedance_ref = 6'h15;
        end
        check(imp_code, 6'h2a, "imp held"); // no update under reads
        idle(5);
        check(imp_code, 6'h15, "imp moved"); // update once quiet
        $display("stream test done");
    endtask

    task automatic t_lanes();
        wr(19'h20, 36'h0, 36'h0, 4'h0, 4'h0);
        for (int i = 0; i < 4; i++) begin
            wr(19'h20, 36'hfffffffff, 36'h123456789, 4'(~(4'h1 << i)), 4'(4'h1 << i));
            cyc(1'b0, 1'b1, 19'h20, G, ~G, 4'h0, 4'h0);
            idle(3);
        end
        $display("byte lane test done");
    endtask

    task automatic t_dll();
        @(negedge clk) dll_off_n = 1'b0;
        repeat (8) @(ctrl.fell);
        check({dll_enable, dll_ready}, 2'b00, "loop off"); // bypass pin low
        @(negedge clk) dll_off_n = 1'b1;
        repeat (2100) @(ctrl.fell);
        check(dll_ready, 1'b1, "locked"); // loop back on
        ctrl.run = 1'b0;
        repeat (20) @(negedge clk);
        check(k_clock_absent, 1'b1, "absent"); // clock loss seen
        ctrl.run = 1'b1;
        repeat (8) @(ctrl.fell);
        check(dll_ready, 1'b0, "loop reset"); // loop restarts on return
        repeat (992) @(ctrl.fell);
        check({k_clock_absent, dll_ready}, 2'b00, "restarting"); // restart wait
        repeat (1200) @(ctrl.fell);
        check(dll_ready, 1'b1, "restarted"); // restart over
        $display("clock stop test done");
    endtask

    // second power-up with the output clock pair tied high
    task automatic t_strap();
        mon_on = 1'b0;
        @(negedge clk) reset = 1'b1;
        out_clk_held_high = 1'b1; // C pair high from power-up
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (6) @(ctrl.fell);
        mon_on = 1'b1;
        repeat (4) @(ctrl.fell);
        check(out_clk_from_k, 1'b1, "strap on"); // data launched from K pair
        @(negedge clk) out_clk_held_high = 1'b0;
        repeat (8) @(ctrl.fell);
        check(out_clk_from_k, 1'b1, "strap fixed"); // mode kept after start
        $display("clock mode test done");
    endtask

    // reset, then the scenarios in order
    initial begin
        reset = 1'b1;
        dll_off_n = 1'b1;
        out_clk_held_high = 1'b0; // output clocks in use from power-up
        impedance_ref = 6'h2a;
        mon_on = 1'b0;
        wv = 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        repeat (6) @(ctrl.fell);
        mon_on = 1'b1;
        t_power();
        t_stream();
        t_lanes();
        t_dll();
        t_strap();
        close_out();
    end

    // watchdog: the run needs about 85 us
    initial begin
        #200us;
        error_cnt++;
        $display("FAIL %0t watchdog expired", $time);
        close_out();
    end
endmodule
